//--- sim/bidc_core_test.sv
`timescale 1ns/1ns
module bidc_core_test;
    typedef struct packed {
        logic wr;
        logic [7:0] out;
        logic [7:0] acc;
        logic [3:0] fl;
    } bidc_note_s;
    logic clk = 1'b0;
    logic reset, opValid, accWrEn, prevV;
    logic [2:0] opCode;
    logic [1:0] addr;
    logic [7:0] memIn, accWrData, memOut_q, accumulator_reg_q, eAcc, eOut;
    logic memWrEn_q, zeroFlag_q, carryFlag_q, aux_nibble_carry_flag_q, signed_overflow_flag_q;
    logic [7:0] eMem [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] eFl = 4'h0;
    logic [31:0] seed = 32'hCDFA1D17;
    bidc_note_s q [$];
    bidc_note_s n;
    int n_fail = 0;
    int tests_run = 0;
    bidc_core dut_u (.clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode),
        .memIn(memIn), .accWrEn(accWrEn), .accWrData(accWrData), .memWrEn_q(memWrEn_q),
        .memOut_q(memOut_q), .accumulator_reg_q(accumulator_reg_q), .zeroFlag_q(zeroFlag_q),
        .carryFlag_q(carryFlag_q), .aux_nibble_carry_flag_q(aux_nibble_carry_flag_q),
        .signed_overflow_flag_q(signed_overflow_flag_q));
    bidc_mem_model modelU (.clk(clk), .reset(reset), .opValid(opValid), .addr(addr),
        .memWrEn(memWrEn_q), .memOut(memOut_q), .memIn(memIn));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // flags as borrow for subtract, carry for add
    function automatic logic [10:0] alu(input logic [7:0] a, b, input logic ci, sub);
        logic [8:0] f;
        logic [4:0] h;
        f = sub ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
        h = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci : {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
        return {f[8], h[4], ((a[7] ^ b[7]) == sub) && (f[7] != a[7]), f[7:0]};
    endfunction
    task automatic chkByte(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected outcome noted before the op is driven
    task automatic op(input logic [2:0] c, input logic [1:0] a, input logic ld,
        input logic [7:0] d);
        logic [10:0] r;
        logic wr;
        wr = 1'b0;
        case (c)
            3'h0: r = alu(eMem[a], eAcc, eFl[2], 1'b1);
            3'h1: r = alu(eAcc, 8'h00, eFl[2], 1'b1);
            3'h2: r = alu(eMem[a], 8'h00, eFl[2], 1'b1);
            3'h3: r = alu(eMem[a], 8'h01, 1'b0, 1'b0);
            3'h4: r = alu(eMem[a], 8'h01, 1'b0, 1'b1);
            default: r = 11'h0;
        endcase
        if (c < 3'h5) eFl = {r[7:0] == 8'h00, r[10:8]};
        if (ld) eAcc = d;
        if (c == 3'h1) eAcc = r[7:0];
        else if (c < 3'h6) begin
            wr = 1'b1;
            eOut = (c == 3'h5) ? 8'h00 : r[7:0];
            eMem[a] = eOut;
        end
        q.push_back('{wr, eOut, eAcc, eFl});
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= c;
        addr <= a;
        accWrEn <= ld;
        accWrData <= d;
    endtask
    task automatic idle;
        @(posedge clk);
        opValid <= 1'b0;
        accWrEn <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (prevV && q.size() > 0) begin
            n = q.pop_front();
            chkByte({7'h00, memWrEn_q}, {7'h00, n.wr});
            chkByte(memOut_q, n.out);
            chkByte(accumulator_reg_q, n.acc);
            chkByte({4'h0, zeroFlag_q, carryFlag_q, aux_nibble_carry_flag_q,
                signed_overflow_flag_q}, {4'h0, n.fl});
        end
        prevV = opValid | accWrEn;
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        {opValid, accWrEn, opCode, addr, accWrData, eAcc, eOut} = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chkByte(accumulator_reg_q, bidc_pkg::ACC_RESET);
        chkByte(memOut_q, bidc_pkg::MEM_RESET);
        // 00 -1 borrows, FF +1 wraps, op 1 beats a load, op 5 keeps flags
        op(3'h4, 2'h0, 1'b0, 8'h00);
        op(3'h3, 2'h0, 1'b0, 8'h00);
        op(3'h3, 2'h0, 1'b0, 8'h00);
        op(3'h7, 2'h0, 1'b1, 8'h80);
        op(3'h0, 2'h1, 1'b0, 8'h00);
        op(3'h1, 2'h0, 1'b1, 8'h55);
        op(3'h5, 2'h1, 1'b0, 8'h00);
        op(3'h6, 2'h2, 1'b0, 8'h00);
        op(3'h2, 2'h1, 1'b0, 8'h00);
        idle();
        $display("test directed done");
        repeat (300) begin
            seed = lfsr(seed);
            op(seed[2:0], seed[4:3], seed[5], seed[15:8]);
        end
        idle();
        $display("test random done");
        wrap_up();
    end
endmodule // bidc_core_test

//--- sim/bidc_mem_model.sv
`timescale 1ns/1ns
// data memory beside the core
module bidc_mem_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic opValid,
    input wire logic [1:0] addr,
    input wire logic memWrEn,
    input wire logic [7:0] memOut,
    output logic [7:0] memIn
);
    logic [7:0] mem [4];
    logic [1:0] wrAddr_q;
    logic [7:0] rd;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrAddr_q <= 2'h0;
            for (int i = 0; i < 4; i++) mem[i] <= 8'h00;
        end else begin
            if (opValid) wrAddr_q <= addr;
            if (memWrEn) mem[wrAddr_q] <= memOut;
        end
    end
    // forward a pending write so back-to-back ops see it
    assign rd = (memWrEn && addr == wrAddr_q) ? memOut : mem[addr];
    // idle bus inverted so a late sample cannot pass
    assign memIn = opValid ? rd : ~rd;
endmodule // bidc_mem_model

//--- verilog/bidc_adder.sv
`timescale 1ns/1ns
// shared 8-bit add/subtract slice with flag outputs
module bidc_adder (
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    input wire logic subtract,
    output logic [7:0] sum,
    output logic carryFlag,
    output logic auxFlag,
    output logic ovFlag
);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] bEff;
    always_comb begin
        // subtract done as a + ~b + ~borrow, carry and aux flags inverted to borrow sense
        bEff = subtract ? ~opB : opB;
        full = {1'b0, opA} + {1'b0, bEff} + {8'h00, subtract ? ~carryIn : carryIn};
        low = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, subtract ? ~carryIn : carryIn};
        sum = full[7:0];
        carryFlag = subtract ? ~full[8] : full[8];
        auxFlag = subtract ? ~low[4] : low[4];
        ovFlag = (opA[7] == bEff[7]) && (sum[7] != opA[7]);
    end
endmodule // bidc_adder

//--- verilog/bidc_core.sv
`timescale 1ns/1ns
// What this block does
// - memory minus accumulator minus carry into memory
// - accumulator minus carry into accumulator
// - memory minus carry into memory
// - increment memory byte, update four flags
// - decrement memory byte, update four flags
// - clear memory byte, flags unchanged
module bidc_core (
    input wire logic clk,
    input wire logic reset,
    input wire logic opValid,
    input wire logic [2:0] opCode,
    input wire logic [7:0] memIn,
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    output logic memWrEn_q,
    output logic [7:0] memOut_q,
    output logic [7:0] accumulator_reg_q,
    output logic zeroFlag_q,
    output logic carryFlag_q,
    output logic aux_nibble_carry_flag_q,
    output logic signed_overflow_flag_q
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] opA;
    logic [7:0] opB;
    logic cin;
    logic sub;
    logic toMem;
    logic toAcc;
    logic setFlags;
    logic legal;
    logic [7:0] res;
    logic cOut;
    logic acOut;
    logic ovOut;
    logic [7:0] wrVal;
    always_comb begin
        opA = memIn;
        opB = bidc_pkg::ZERO_BYTE;
        cin = carryFlag_q;
        sub = 1'b1;
        toMem = 1'b0;
        toAcc = 1'b0;
        setFlags = 1'b0;
        legal = 1'b1;
        unique case (opCode)
            bidc_pkg::OP_SUB_MEM_ACC_BORROW: begin
                opB = accumulator_reg_q;
                toMem = 1'b1;
                setFlags = 1'b1;
            end
            bidc_pkg::OP_SUB_ACC_BORROW: begin
                opA = accumulator_reg_q;
                toAcc = 1'b1;
                setFlags = 1'b1;
            end
            bidc_pkg::OP_SUB_MEM_BORROW: begin
                toMem = 1'b1;
                setFlags = 1'b1;
            end
            bidc_pkg::OP_INC_MEM: begin
                opB = bidc_pkg::ONE_BYTE;
                cin = 1'b0;
                sub = 1'b0;
                toMem = 1'b1;
                setFlags = 1'b1;
            end
            bidc_pkg::OP_DEC_MEM: begin
                opB = bidc_pkg::ONE_BYTE;
                cin = 1'b0;
                toMem = 1'b1;
                setFlags = 1'b1;
            end
            bidc_pkg::OP_CLEAR_MEM: begin
                toMem = 1'b1;
            end
            // codes 6 and 7 are unused and do nothing
            default: legal = 1'b0;
        endcase
    end
    bidc_adder u_adder (
        .opA(opA),
        .opB(opB),
        .carryIn(cin),
        .subtract(sub),
        .sum(res),
        .carryFlag(cOut),
        .auxFlag(acOut),
        .ovFlag(ovOut)
    );
    assign wrVal = (opCode == 3'(bidc_pkg::OP_CLEAR_MEM)) ? bidc_pkg::ZERO_BYTE : res;
    ////////////////////////////////////////////////////////////////
    // memory write-back, one cycle after the op
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            memWrEn_q <= 1'b0;
            memOut_q <= bidc_pkg::MEM_RESET;
        end else begin
            memWrEn_q <= opValid && legal && toMem;
            if (opValid && legal && toMem) begin
                memOut_q <= wrVal;
            end
        end
    end
    // accumulator; op result wins over a direct load in same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            accumulator_reg_q <= bidc_pkg::ACC_RESET;
        end else if (opValid && legal && toAcc) begin
            accumulator_reg_q <= res;
        end else if (accWrEn) begin
            accumulator_reg_q <= accWrData;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zeroFlag_q <= bidc_pkg::FLAG_RESET;
            carryFlag_q <= bidc_pkg::FLAG_RESET;
            aux_nibble_carry_flag_q <= bidc_pkg::FLAG_RESET;
            signed_overflow_flag_q <= bidc_pkg::FLAG_RESET;
        end else if (opValid && legal && setFlags) begin
            zeroFlag_q <= (res == bidc_pkg::ZERO_BYTE);
            carryFlag_q <= cOut;
            aux_nibble_carry_flag_q <= acOut;
            signed_overflow_flag_q <= ovOut;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_mem_acc_sub;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_ACC_BORROW) |=>
            memWrEn_q && memOut_q == 8'($past(memIn) - $past(accumulator_reg_q)
            - {7'h00, $past(carryFlag_q)});
    endproperty
    a_mem_acc_sub: assert property (p_mem_acc_sub) else $error("mem-acc subtract wrong");
    property p_acc_sub;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_ACC_BORROW) |=>
            !memWrEn_q && accumulator_reg_q == 8'($past(accumulator_reg_q)
            - {7'h00, $past(carryFlag_q)});
    endproperty
    a_acc_sub: assert property (p_acc_sub) else $error("acc subtract wrong");
    property p_mem_sub;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_BORROW) |=>
            memWrEn_q && memOut_q == 8'($past(memIn) - {7'h00, $past(carryFlag_q)});
    endproperty
    a_mem_sub: assert property (p_mem_sub) else $error("mem subtract wrong");
    property p_inc;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_INC_MEM) |=>
            memOut_q == 8'($past(memIn) + 8'h01) && carryFlag_q == ($past(memIn) == 8'hFF);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");
    property p_dec;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_DEC_MEM) |=>
            memOut_q == 8'($past(memIn) - 8'h01) && carryFlag_q == ($past(memIn) == 8'h00);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_clear;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_CLEAR_MEM) |=>
            memWrEn_q && memOut_q == 8'h00 && $stable(zeroFlag_q) && $stable(carryFlag_q)
            && $stable(aux_nibble_carry_flag_q) && $stable(signed_overflow_flag_q);
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong or flags moved");
    property p_zero;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_DEC_MEM) |=>
            zeroFlag_q == (memOut_q == 8'h00)
            && aux_nibble_carry_flag_q == ($past(memIn[3:0]) == 4'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero or aux flag wrong");
    property p_ov;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_INC_MEM) |=>
            signed_overflow_flag_q == ($past(memIn) == 8'h7F);
    endproperty
    a_ov: assert property (p_ov) else $error("overflow flag wrong");
    property p_mac_flags;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_ACC_BORROW) |=>
            carryFlag_q == ({1'b0, $past(memIn)} < ({1'b0, $past(accumulator_reg_q)}
            + {8'h00, $past(carryFlag_q)}))
            && zeroFlag_q == (memOut_q == 8'h00);
    endproperty
    a_mac_flags: assert property (p_mac_flags) else $error("mem-acc flags wrong");
    property p_acc_flags;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_ACC_BORROW) |=>
            carryFlag_q == ($past(accumulator_reg_q) == 8'h00 && $past(carryFlag_q))
            && zeroFlag_q == (accumulator_reg_q == 8'h00);
    endproperty
    a_acc_flags: assert property (p_acc_flags) else $error("acc subtract flags wrong");
    property p_mem_flags;
        @(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_BORROW) |=>
            carryFlag_q == ($past(memIn) == 8'h00 && $past(carryFlag_q))
            && signed_overflow_flag_q == ($past(memIn) == 8'h80 && $past(carryFlag_q));
    endproperty
    a_mem_flags: assert property (p_mem_flags) else $error("mem subtract flags wrong");
    // idle cycles, clear and unused codes must not disturb flags
    property p_flag_hold;
        @(posedge clk) disable iff (reset)
        !(opValid && opCode < 3'(bidc_pkg::OP_CLEAR_MEM)) |=>
            $stable(zeroFlag_q) && $stable(carryFlag_q)
            && $stable(aux_nibble_carry_flag_q) && $stable(signed_overflow_flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags moved without op");
    c_borrow: cover property (@(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_ACC_BORROW) ##1 carryFlag_q);
    c_inc_wrap: cover property (@(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_INC_MEM) ##1 zeroFlag_q);
    c_clear: cover property (@(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_CLEAR_MEM));
    c_acc_borrow: cover property (@(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_ACC_BORROW) ##1 carryFlag_q);
    c_mem_ov: cover property (@(posedge clk) disable iff (reset)
        opValid && opCode == 3'(bidc_pkg::OP_SUB_MEM_BORROW) ##1 signed_overflow_flag_q);
endmodule // bidc_core

//--- verilog/bidc_pkg.sv
package bidc_pkg;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    // operation codes seen on the op port
    typedef enum logic [2:0] {
        OP_SUB_MEM_ACC_BORROW,
        OP_SUB_ACC_BORROW,
        OP_SUB_MEM_BORROW,
        OP_INC_MEM,
        OP_DEC_MEM,
        OP_CLEAR_MEM
    } bidc_op_e;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] MEM_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic FLAG_RESET = 1'b0;
endpackage
